// ### design/mode_select_defs.svh
// Constants for the per-device mode register select block
//
// What this block does
// - In select mode the lane-zero qualifier is caught on a strobe edge.
// - Fixed bursts of four or eight beats work; per-command bursts are spaced as eight beats.
// - Bit 4 of mode register 3 turns the mode on and resets to zero.
// - In the mode, a mode register write runs only when the qualifier is low.
// - Clearing bit 4 of mode register 3 with a low qualifier exits.
// - Dynamic write termination is off while the mode is on.
// - Nominal termination follows the termination pin in the mode.
`ifndef MODE_SELECT_DEFS_SVH
`define MODE_SELECT_DEFS_SVH

// ****************************************************************
// APB register map
// ****************************************************************
`define REG_MR_BASE     8'h00
`define REG_MR_LAST     8'h18
`define REG_STATUS      8'h1c
`define REG_TIMING      8'h20
`define REG_COUNTS      8'h24

// ****************************************************************
// Mode register fields
// ****************************************************************
`define MR_SELECT_BIT   4
`define MR_SELECT_IDX   3'h3
`define MR_NOMTERM_IDX  3'h1
`define MR_PARITY_IDX   3'h5
`define MR_BURST_IDX    3'h0
`define BURST_CHOP4     2'h2
`define MR_RESET        14'h0000

// ****************************************************************
// Timing, in link clock edges
// ****************************************************************
`define TIMING_RESET    32'h0000_0c0a
`define QUAL_TIMEOUT    6'h20
`define PL_4            5'h04
`define PL_5            5'h05
`define PL_6            5'h06
`define PL_8            5'h08

`endif

// ### design/mode_select_pkg.sv
// Types for the per-device mode register select block
package mode_select_pkg;

    // Command and data pins, as seen on the memory side
    typedef struct packed {
        logic        ck;
        logic        cs_n;
        logic        act_n;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [17:0] a;
        logic [7:0]  dq;
        logic        dqs;
        logic        odt;
    } ddr_pins_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_LAT,
        ST_WAIT_DQS
    } qual_state_t;

    // One mode register update
    typedef struct packed {
        logic [2:0]  sel;
        logic [13:0] data;
    } mr_write_t;

endpackage

// ### design/mode_select.sv
// Per-device mode register select: command decode, qualifier, registers
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mode_select_defs.svh"

module mode_select (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire mode_select_pkg::ddr_pins_t pins,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic                           select_mode,
    output mode_select_pkg::mr_write_t     mr_write,
    output logic                           mr_write_valid,
    output logic                           mr_drop,
    output logic                           nom_term_on,
    output logic                           dyn_term_allowed
);
    import mode_select_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    ddr_pins_t meta_q;
    ddr_pins_t pin_q;
    logic      ck_old_q;
    logic      dqs_old_q;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q    <= '0;
            pin_q     <= '0;
            ck_old_q  <= 1'b0;
            dqs_old_q <= 1'b0;
        end else begin
            meta_q    <= pins;
            pin_q     <= meta_q;
            ck_old_q  <= pin_q.ck;
            dqs_old_q <= pin_q.dqs;
        end
    end

    logic ck_rise;
    logic dqs_fall;
    logic cmd_sel;
    logic is_mrs;
    logic [2:0] cmd_mr;

    assign ck_rise  = pin_q.ck & ~ck_old_q;
    assign dqs_fall = ~pin_q.dqs & dqs_old_q;
    assign cmd_sel  = ck_rise & ~pin_q.cs_n;
    // Row, column and write strobes share address lines 16..14
    assign is_mrs   = pin_q.act_n & ~pin_q.a[16] & ~pin_q.a[15]
                      & ~pin_q.a[14];
    assign cmd_mr   = {pin_q.bg[0], pin_q.ba};

    // ****************************************************************
    // Mode registers
    // ****************************************************************
    logic [13:0] mr_q [0:7];
    logic        select_q;
    logic        commit;
    mr_write_t   commit_w;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                mr_q[i] <= `MR_RESET;
            end
        end else if (commit) begin
            mr_q[commit_w.sel] <= commit_w.data;
        end
    end

    // Entry is unqualified; exit needs the low qualifier like any write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            select_q <= 1'b0;
        end else if (commit && commit_w.sel == `MR_SELECT_IDX) begin
            select_q <= commit_w.data[`MR_SELECT_BIT];
        end
    end

    // ****************************************************************
    // Latencies
    // ****************************************************************
    logic [31:0] timing_q;
    logic [4:0]  pl;
    logic [4:0]  al;
    logic [4:0]  write_column_latency;
    logic [4:0]  upd;
    logic [2:0]  half_bl;
    logic [7:0]  wl;
    logic [7:0]  spacing;

    // Software gives write and additive latency in link clocks
    assign write_column_latency = timing_q[4:0];
    assign al  = timing_q[9:5];
    assign upd = timing_q[14:10];

    always_comb begin
        case (mr_q[`MR_PARITY_IDX][2:0])
            3'h1:    pl = `PL_4;
            3'h2:    pl = `PL_5;
            3'h3:    pl = `PL_6;
            3'h4:    pl = `PL_8;
            default: pl = 5'h00;
        endcase
    end

    // Per-command choice is treated as eight beats for spacing
    assign half_bl = (mr_q[`MR_BURST_IDX][1:0] == `BURST_CHOP4) ?
                     3'h2 : 3'h4;
    assign wl      = {3'h0, al} + {3'h0, write_column_latency} + {3'h0, pl};
    // The half clock lost is taken up by counting whole edges
    assign spacing = wl + {5'h00, half_bl} + {3'h0, upd};

    // ****************************************************************
    // Qualifier capture
    // ****************************************************************
    qual_state_t state_q;
    mr_write_t   pend_q;
    logic [7:0]  lat_cnt_q;
    logic [5:0]  tmo_q;
    logic        drop;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            pend_q    <= '0;
            lat_cnt_q <= 8'h00;
            tmo_q     <= 6'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_sel && is_mrs && select_q) begin
                        pend_q    <= '{sel: cmd_mr, data: pin_q.a[13:0]};
                        lat_cnt_q <= wl;
                        state_q   <= ST_WAIT_LAT;
                    end
                end
                ST_WAIT_LAT: begin
                    // Strobe opens at the latency rise; its first fall follows
                    if (ck_rise) begin
                        if (lat_cnt_q <= 8'h01) begin
                            tmo_q   <= `QUAL_TIMEOUT;
                            state_q <= ST_WAIT_DQS;
                        end else begin
                            lat_cnt_q <= lat_cnt_q - 8'h01;
                        end
                    end
                end
                ST_WAIT_DQS: begin
                    // First falling strobe edge after the write latency
                    if (dqs_fall) begin
                        state_q <= ST_IDLE;
                    end else if (ck_rise) begin
                        if (tmo_q == 6'h00) begin
                            state_q <= ST_IDLE;
                        end else begin
                            tmo_q <= tmo_q - 6'h01;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Decide on lane zero only; a missing strobe drops the write
    always_comb begin
        commit   = 1'b0;
        drop     = 1'b0;
        commit_w = pend_q;
        if (state_q == ST_IDLE && cmd_sel && is_mrs && !select_q) begin
            commit   = 1'b1;
            commit_w = '{sel: cmd_mr, data: pin_q.a[13:0]};
        end else if (state_q == ST_WAIT_DQS && dqs_fall) begin
            commit = ~pin_q.dq[0];
            drop   = pin_q.dq[0];
        end else if (state_q == ST_WAIT_DQS && ck_rise && tmo_q == 6'h00) begin
            drop = 1'b1;
        end
    end

    // ****************************************************************
    // Spacing and illegal command watch
    // ****************************************************************
    logic [7:0] gap_q;
    logic       gap_err_q;
    logic       bad_cmd_q;
    logic [15:0] ok_cnt_q;
    logic [15:0] drop_cnt_q;
    logic       sw_clr_gap;
    logic       sw_clr_bad;
    logic       gap_short;
    logic       bad_cmd;

    assign gap_short = cmd_sel && is_mrs && select_q && gap_q < spacing;
    // Deselect and no-operation carry all strobes high
    assign bad_cmd   = cmd_sel && select_q && !is_mrs
                       && !(pin_q.act_n && pin_q.a[16] && pin_q.a[15]
                            && pin_q.a[14]);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gap_q <= 8'hff;
        end else if (cmd_sel && is_mrs) begin
            gap_q <= 8'h01;
        end else if (ck_rise && gap_q != 8'hff) begin
            gap_q <= gap_q + 8'h01;
        end
    end

    // A new event beats a software clear in the same cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gap_err_q <= 1'b0;
        end else if (gap_short) begin
            gap_err_q <= 1'b1;
        end else if (sw_clr_gap) begin
            gap_err_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bad_cmd_q <= 1'b0;
        end else if (bad_cmd) begin
            bad_cmd_q <= 1'b1;
        end else if (sw_clr_bad) begin
            bad_cmd_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ok_cnt_q   <= 16'h0000;
            drop_cnt_q <= 16'h0000;
        end else begin
            if (commit && select_q) begin
                ok_cnt_q <= ok_cnt_q + 16'h0001;
            end
            if (drop) begin
                drop_cnt_q <= drop_cnt_q + 16'h0001;
            end
        end
    end

    // ****************************************************************
    // APB slave, one wait state on every access
    // ****************************************************************
    logic access;

    assign access     = psel & penable & ~pready;
    assign sw_clr_gap = access & pwrite & (paddr == `REG_STATUS) & pwdata[1];
    assign sw_clr_bad = access & pwrite & (paddr == `REG_STATUS) & pwdata[2];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timing_q <= `TIMING_RESET;
        end else if (access && pwrite && paddr == `REG_TIMING) begin
            timing_q <= {17'h00000, pwdata[14:0]};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (access) begin
                if (paddr[1:0] != 2'h0) begin
                    pslverr <= 1'b1;
                end else if (paddr <= `REG_MR_LAST) begin
                    pslverr <= pwrite;
                    prdata  <= {18'h00000, mr_q[paddr[4:2]]};
                end else if (paddr == `REG_STATUS) begin
                    prdata <= {27'h0, state_q, bad_cmd_q, gap_err_q,
                               select_q};
                end else if (paddr == `REG_TIMING) begin
                    prdata <= timing_q;
                end else if (paddr == `REG_COUNTS) begin
                    pslverr <= pwrite;
                    prdata  <= {drop_cnt_q, ok_cnt_q};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Outputs and termination
    // ****************************************************************
    logic nom_en;

    assign nom_en = mr_q[`MR_NOMTERM_IDX][10:8] != 3'h0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            select_mode      <= 1'b0;
            mr_write         <= '0;
            mr_write_valid   <= 1'b0;
            mr_drop          <= 1'b0;
            nom_term_on      <= 1'b0;
            dyn_term_allowed <= 1'b0;
        end else begin
            select_mode      <= select_q;
            mr_write         <= commit_w;
            mr_write_valid   <= commit;
            mr_drop          <= drop;
            // Pin path only; skew and async delays lie in the pad
            nom_term_on      <= select_q ? (nom_en & pin_q.odt)
                                         : nom_en;
            dyn_term_allowed <= ~select_q;
        end
    end

endmodule
`default_nettype wire

// ### sim/mode_select_monitor.sv
// Checker for the per-device mode register select block
`timescale 1ns/1ps
`default_nettype none
module mode_select_monitor (
    input wire logic                       mclk,
    input wire logic                       rst,
    input wire mode_select_pkg::ddr_pins_t pins,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       select_mode,
    input wire mode_select_pkg::mr_write_t mr_write,
    input wire logic                       mr_write_valid,
    input wire logic                       mr_drop,
    input wire logic                       nom_term_on,
    input wire logic                       dyn_term_allowed
);
    import mode_select_pkg::*;
    // ********
    // Sequences
    // ********
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence apb_taken;
        psel && penable && !pready;
    endsequence
    sequence mr3_update(on);
        mr_write_valid && mr_write.sel == 3'h3 && mr_write.data[4] == on;
    endsequence
    // Pin passes two sync flops, so five cycles is settled
    sequence term_pin_low;
        (select_mode && !pins.odt)[*5];
    endsequence
    // ********
    // Assertions
    // ********
    AST_APB_ONE_WAIT: assert property (apb_taken |=> pready)
        else $error("pready missing after one wait state");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_MODE_ENTRY: assert property (
        mr3_update(1'b1) |-> ##[1:3] select_mode)
        else $error("select mode not entered");
    AST_MODE_EXIT: assert property (
        mr3_update(1'b0) |-> ##[1:3] !select_mode)
        else $error("select mode not left");
    AST_NO_DYN_TERM: assert property (
        select_mode [*3] |-> !dyn_term_allowed)
        else $error("dynamic termination allowed in select mode");
    AST_TERM_FOLLOWS_PIN: assert property (
        term_pin_low |-> !nom_term_on)
        else $error("termination on while pin low");
    AST_ONE_OUTCOME: assert property (
        mr_write_valid |-> !mr_drop)
        else $error("update both applied and dropped");
    AST_DROP_IN_MODE: assert property (mr_drop |-> $past(select_mode))
        else $error("drop outside select mode");
    AST_DROP_KEEPS_MODE: assert property (
        mr_drop |-> select_mode ##1 select_mode [*3])
        else $error("dropped update changed the mode");
    AST_UPDATE_PULSE: assert property (mr_write_valid |=> !mr_write_valid)
        else $error("update strobe longer than one cycle");
endmodule
`default_nettype wire

// ### sim/ddr_ctrl_model.sv
// Memory controller model driving command, strobe and data lanes
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model (
    input  wire logic [4:0]                wl,
    input  wire logic                      odt_req,
    output var mode_select_pkg::ddr_pins_t pins
);
    import mode_select_pkg::*;
    // ********
    // Link clock and termination pin
    // ********
    // Offset keeps link edges off the block's clock edges
    initial begin
        pins = '0;
        pins.cs_n = 1'b1;
        pins.act_n = 1'b1;
        #1.3;
        forever #62.5 pins.ck = ~pins.ck;
    end
    always @(odt_req) pins.odt <= odt_req;
    // ********
    // Mode register set, qualified by lane zero
    // ********
    // Write leveling assumed done before entry
    task automatic mrs(input logic [2:0] idx, input logic [13:0] data,
                       input logic [7:0] dq, input int beats,
                       input int gap);
        @(negedge pins.ck);
        pins.cs_n <= 1'b0;
        pins.act_n <= 1'b1;
        pins.a <= {4'h0, data};
        pins.bg <= {1'b0, idx[2]};
        pins.ba <= idx[1:0];
        @(negedge pins.ck);
        pins.cs_n <= 1'b1;
        pins.a <= ~pins.a;
        pins.dq <= dq;
        if (beats > 0) begin
            repeat (wl) @(posedge pins.ck);
            repeat (beats / 2) begin
                pins.dqs <= 1'b1;
                @(negedge pins.ck);
                pins.dqs <= 1'b0;
                @(posedge pins.ck);
            end
        end
        pins.dq <= ~dq;
        repeat (gap) @(posedge pins.ck);
    endtask
    // Any other command, to trip the illegal command watch
    task automatic cmd(input logic [2:0] strobes);
        @(negedge pins.ck);
        pins.cs_n <= 1'b0;
        pins.act_n <= 1'b1;
        pins.a[16:14] <= strobes;
        @(negedge pins.ck);
        pins.cs_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ### sim/mode_select_tb.sv
// Testbench for the per-device mode register select block
`timescale 1ns/1ps
`default_nettype none
`include "mode_select_defs.svh"
module mode_select_tb;
    import mode_select_pkg::*;
    typedef struct packed {
        logic [2:0] idx; logic [13:0] data; logic [7:0] dq;
        logic [3:0] beats; logic hit;
    } qual_t;
    // Write latency implied by the timing reset value, no parity
    localparam logic [4:0] WL = 5'h0a;
    localparam qual_t QT [5] = '{'{3'h2, 14'h0055, 8'h01, 4'h8, 1'b0},
        '{3'h2, 14'h0055, 8'hfe, 4'h8, 1'b1},
        '{3'h0, 14'h0002, 8'h00, 4'h8, 1'b1},
        '{3'h4, 14'h0123, 8'h00, 4'h4, 1'b1},
        '{3'h6, 14'h0033, 8'h00, 4'h0, 1'b0}};
    localparam logic [7:0] BAD [4] = '{8'h0c, `REG_COUNTS, 8'h28, 8'h1e};
    logic        mclk, rst, psel, penable, pwrite, odt_req, err;
    logic        pready, pslverr, select_mode, mr_write_valid, mr_drop;
    logic        nom_term_on, dyn_term_allowed;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [13:0] mr_exp [7];
    ddr_pins_t   pins;
    mr_write_t   mr_write;
    int          errors = 0;
    int          checked = 0;

    ddr_ctrl_model ctrl_u (.wl(WL), .odt_req(odt_req), .pins(pins));
    mode_select dut_u (.mclk(mclk), .rst(rst), .pins(pins), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .select_mode(select_mode),
        .mr_write(mr_write), .mr_write_valid(mr_write_valid),
        .mr_drop(mr_drop), .nom_term_on(nom_term_on),
        .dyn_term_allowed(dyn_term_allowed));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ********
    // Tasks
    // ********
    task automatic summarize();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // No fixed latency assumed; the bound only cuts a hang
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] wdata, output logic [31:0] rd_v,
                       output logic err_v);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            summarize();
        end
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        apb(1'b0, a, 32'h0, rdata, err);
        chk(what, exp, rdata);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // ********
    // Scenarios
    // ********
    initial begin
        {rst, psel, penable, pwrite, odt_req} = 5'h10;
        paddr = 8'h00;
        pwdata = 32'h0;
        foreach (mr_exp[i]) mr_exp[i] = 14'h0000;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd(`REG_STATUS, 32'h0, "status");
        rd(8'h0c, 32'h0, "mr3 reset");
        rd(`REG_TIMING, `TIMING_RESET, "timing");
        for (int i = 0; i < 4; i++) begin
            apb(i < 2, BAD[i], 32'hffff_ffff, rdata, err);
            chk("slave error", 32'h1, {31'h0, err});
        end
        rd(8'h0c, 32'h0, "mr3 after refused write");
        ctrl_u.mrs(3'h1, 14'h0100, 8'h00, 0, 4);
        chk("nominal term", 32'h1, {31'h0, nom_term_on});
        ctrl_u.mrs(3'h3, 14'h0010, 8'h00, 0, 20);
        mr_exp[1] = 14'h0100;
        mr_exp[3] = 14'h0010;
        chk("select mode", 32'h1, {31'h0, select_mode});
        chk("dyn term", 32'h0, {31'h0, dyn_term_allowed});
        chk("term pin low", 32'h0, {31'h0, nom_term_on});
        odt_req <= 1'b1;
        settle(10);
        chk("term pin high", 32'h1, {31'h0, nom_term_on});
        for (int i = 0; i < 5; i++) begin
            ctrl_u.mrs(QT[i].idx, QT[i].data, QT[i].dq, int'(QT[i].beats),
                       QT[i].beats == 4'h0 ? 48 : 6);
            if (QT[i].hit) mr_exp[QT[i].idx] = QT[i].data;
            rd({3'h0, QT[i].idx, 2'h0}, {18'h0, mr_exp[QT[i].idx]},
               "mode register");
        end
        rd(`REG_STATUS, 32'h1, "status before spacing");
        // Second update lands before the spacing has run out
        ctrl_u.mrs(3'h5, 14'h0000, 8'h00, 4, 0);
        ctrl_u.mrs(3'h5, 14'h0000, 8'h00, 4, 6);
        rd(`REG_STATUS, 32'h3, "status spacing");
        apb(1'b1, `REG_STATUS, 32'h2, rdata, err);
        rd(`REG_STATUS, 32'h1, "status cleared");
        ctrl_u.cmd(3'h4);
        rd(`REG_STATUS, 32'h5, "status illegal");
        apb(1'b1, `REG_STATUS, 32'h4, rdata, err);
        rd(`REG_STATUS, 32'h1, "illegal cleared");
        ctrl_u.mrs(3'h3, 14'h0000, 8'h01, 4, 6);
        chk("mode after high exit", 32'h1, {31'h0, select_mode});
        ctrl_u.mrs(3'h3, 14'h0000, 8'h00, 4, 6);
        chk("mode after exit", 32'h0, {31'h0, select_mode});
        chk("dyn term after exit", 32'h1, {31'h0, dyn_term_allowed});
        rd(8'h0c, 32'h0, "mr3 after exit");
        apb(1'b0, `REG_COUNTS, 32'h0, rdata, err);
        chk("drop count", 32'h3, {16'h0, rdata[31:16]});
        chk("update count", 32'h6, {16'h0, rdata[15:0]});
        summarize();
    end
endmodule
bind mode_select mode_select_monitor mon_u (.mclk(mclk), .rst(rst),
    .pins(pins), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .select_mode(select_mode), .mr_write(mr_write),
    .mr_write_valid(mr_write_valid), .mr_drop(mr_drop),
    .nom_term_on(nom_term_on), .dyn_term_allowed(dyn_term_allowed));
`default_nettype wire
